// ===== rtl/module_power_mgmt_boot_select.sv
`timescale 1ns/1ps
`include "pm_boot_consts.svh"
// What this block does
// - Power-bad low keeps all module and carrier supply enables off.
// - Standby output goes low in standby power state, high otherwise.
// - Carrier pulls reset input low; module stays in reset while it is low.
// - Power button, sleep and lid inputs are debounced before use.
// - Button is level-sensed during boot, holding it stops boot; edge-sensed after.
// - Low lid input means lid closed and may start sleep.
// - Low battery-low input is reported to power management as battery low.
// - Low test input invokes the module test function.
// - Low bus alert input is an interrupt request from the management bus.
// - Boot device decoded from three straps, ground asserted, float deasserted.
// - Only ground,float,float selects carrier SPI; the other seven patterns each select another source, all floating on-module SPI.
// - Flash and audio data-out pins are sampled as straps during reset.
module module_power_mgmt_boot_select
	import pm_boot_pkg::*;
#(
	parameter int DEB_CYCLES = `PM_DEB_CYCLES,
	parameter int RST_CYCLES = `PM_RST_HOLD_CYCLES
)(
	input  wire logic         ref_clk,
	input  wire logic         rstn,
	input  wire logic         input_power_bad_n,
	input  wire logic         reset_in_n,
	input  wire logic         power_button_n,
	input  wire logic         sleep_n,
	input  wire logic         lid_n,
	input  wire logic         battery_low_n,
	input  wire logic         charging_n,
	input  wire logic         charger_present_n,
	input  wire logic         test_n,
	input  wire logic         pm_bus_alert_n,
	input  wire logic         boot_strap_bit0_n,
	input  wire logic         boot_strap_bit1_n,
	input  wire logic         boot_strap_bit2_n,
	input  wire logic         flash_data_out_strap,
	input  wire logic         audio_data_out_strap,
	input  wire logic         standby_req,
	input  wire logic         boot_done,
	output logic              supply_enable,
	output logic              carrier_power_on,
	output logic              carrier_standby_n,
	output logic              module_reset_n,
	output logic              boot_halted,
	output logic              power_button_event,
	output logic              sleep_request,
	output logic              lid_closed,
	output logic              battery_low,
	output logic              charging,
	output logic              charger_present,
	output logic              test_mode,
	output logic              pm_alert_irq,
	output boot_source_t      boot_source,
	output logic              boot_from_carrier_spi,
	output logic              flash_strap_q,
	output logic              audio_strap_q
);

	localparam int NSYNC = 16;
	localparam int DEB_LAST = DEB_CYCLES - 1;

	////////////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for every carrier pin

	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;

	assign pin_raw = {audio_data_out_strap, flash_data_out_strap, boot_strap_bit2_n,
		boot_strap_bit1_n, boot_strap_bit0_n, pm_bus_alert_n, test_n,
		charger_present_n, charging_n, battery_low_n, reset_in_n, input_power_bad_n,
		1'b1, lid_n, sleep_n, power_button_n};

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync1_q <= {NSYNC{`PM_PIN_IDLE}};
			sync2_q <= {NSYNC{`PM_PIN_IDLE}};
		end
		else
		begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
		end
	end

	logic       pwr_ok_s;
	logic       rst_in_s;
	logic [2:0] strap_s;
	logic [1:0] cfg_s;

	assign pwr_ok_s = sync2_q[4];
	assign rst_in_s = sync2_q[5];
	assign strap_s  = sync2_q[13:11];
	assign cfg_s    = sync2_q[15:14];

	////////////////////////////////////////////////////////////////////////////////
	// Debouncers: the level moves only after the input held still for DEB_CYCLES

	logic [`PM_DEB_NUM-1:0] deb_q;
	logic [15:0]            deb_cnt_q [`PM_DEB_NUM];

	for (genvar i = 0; i < `PM_DEB_NUM; i++)
	begin : g_deb
		wire differs = sync2_q[i] != deb_q[i];
		wire settled = deb_cnt_q[i] == 16'(DEB_LAST);
		always_ff @(posedge ref_clk or negedge rstn)
		begin
			if (!rstn)
			begin
				deb_q[i]     <= `PM_PIN_IDLE;
				deb_cnt_q[i] <= 16'h0000;
			end
			else if (!differs)
				deb_cnt_q[i] <= 16'h0000;
			else if (settled)
			begin
				deb_q[i]     <= sync2_q[i];
				deb_cnt_q[i] <= 16'h0000;
			end
			else
				deb_cnt_q[i] <= deb_cnt_q[i] + 16'h0001;
		end
	end

	wire button_held = !deb_q[`PM_DEB_BUTTON];

	////////////////////////////////////////////////////////////////////////////////
	// Power and reset sequencer

	pm_state_t   state_q;
	pm_state_t   state_d;
	logic [15:0] rst_cnt_q;
	wire         rst_done = rst_cnt_q == 16'(RST_CYCLES - 1);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_OFF:     state_d = ST_RESET;
			ST_RESET:   if (rst_done && rst_in_s) state_d = ST_BOOT;
			// A held button parks the boot here until it is let go
			ST_BOOT:    if (boot_done && !button_held) state_d = ST_RUN;
			ST_RUN:     if (standby_req) state_d = ST_STANDBY;
			ST_STANDBY: if (!standby_req) state_d = ST_RUN;
			default:    state_d = ST_OFF;
		endcase
		if (!rst_in_s && state_d != ST_OFF)
			state_d = ST_RESET;
		if (!pwr_ok_s)
			state_d = ST_OFF;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			state_q <= ST_OFF;
		else
			state_q <= state_d;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			rst_cnt_q <= 16'h0000;
		else if (state_q != ST_RESET || !rst_in_s)
			rst_cnt_q <= 16'h0000;
		else if (!rst_done)
			rst_cnt_q <= rst_cnt_q + 16'h0001;
	end

	// Supervisory logic stays alive; only the gated rails follow the state
	assign supply_enable     = state_q != ST_OFF;
	assign carrier_power_on  = state_q != ST_OFF;
	assign carrier_standby_n = state_q != ST_STANDBY;
	assign module_reset_n    = state_q != ST_OFF && state_q != ST_RESET;
	assign boot_halted       = state_q == ST_BOOT && button_held;

	////////////////////////////////////////////////////////////////////////////////
	// Run-time button edge and status levels

	logic button_prev_q;
	logic press_q;
	wire  run_phase = state_q == ST_RUN || state_q == ST_STANDBY;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			button_prev_q <= 1'b0;
			press_q       <= 1'b0;
		end
		else
		begin
			button_prev_q <= button_held;
			press_q       <= run_phase && button_held && !button_prev_q;
		end
	end

	assign power_button_event = press_q;
	assign lid_closed         = !deb_q[`PM_DEB_LID];
	// Lid closure is folded into the sleep request for the power manager
	assign sleep_request      = !deb_q[`PM_DEB_SLEEP] || lid_closed;
	assign battery_low        = !sync2_q[6];
	assign charging           = !sync2_q[7];
	assign charger_present    = !sync2_q[8];
	assign test_mode          = !sync2_q[9];
	assign pm_alert_irq       = !sync2_q[10];

	////////////////////////////////////////////////////////////////////////////////
	// Straps: captured on the edge that releases module reset

	logic [2:0] boot_code_q;
	logic [1:0] cfg_q;
	wire        strap_take = state_q == ST_RESET && state_d == ST_BOOT;

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			boot_code_q <= `PM_BOOT_CODE_RST;
			cfg_q       <= `PM_CFG_RST;
		end
		else if (strap_take)
		begin
			boot_code_q <= strap_s;
			cfg_q       <= cfg_s;
		end
	end

	assign boot_source           = boot_source_t'(boot_code_q);
	assign boot_from_carrier_spi = boot_code_q == `PM_CARRIER_SPI_PAT;
	assign flash_strap_q         = cfg_q[1'b0];
	assign audio_strap_q         = cfg_q[1'b1];

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	supply_gate_a: assert property (!pwr_ok_s |=> !supply_enable && !carrier_power_on)
		else $error("supplies enabled while power bad");
	carrier_on_a: assert property ($rose(carrier_power_on) |-> $past(pwr_ok_s))
		else $error("carrier power-on raised without power good");
	standby_out_a: assert property (
		state_q == ST_RUN && standby_req && pwr_ok_s && rst_in_s |=> !carrier_standby_n)
		else $error("standby output not low in standby");
	reset_hold_a: assert property (!rst_in_s |=> !module_reset_n [*2])
		else $error("module left reset while reset input low");
	deb_stable_a: assert property ($changed(deb_q[0]) |->
		$past(deb_cnt_q[0]) == 16'(DEB_LAST))
		else $error("debounced button moved before settle count");
	boot_hold_a: assert property (state_q == ST_BOOT && button_held && pwr_ok_s && rst_in_s
		|=> state_q == ST_BOOT)
		else $error("boot continued with button held");
	lid_sleep_a: assert property (!deb_q[`PM_DEB_LID] |-> sleep_request)
		else $error("lid closed without sleep request");
	carrier_spi_a: assert property (boot_from_carrier_spi |->
		boot_source == BOOT_CARRIER_SPI)
		else $error("carrier spi selected on wrong pattern");
	strap_take_a: assert property ($rose(module_reset_n) |->
		boot_code_q == $past(strap_s) && cfg_q == $past(cfg_s))
		else $error("straps not captured at reset release");
	// Pin held low for three samples has crossed both synchroniser flops
	alert_a: assert property (!pm_bus_alert_n [*3] |-> pm_alert_irq)
		else $error("bus alert not raised");

	boot_done_c: cover property (state_q == ST_BOOT ##1 state_q == ST_RUN);
	standby_c:   cover property (carrier_standby_n ##1 !carrier_standby_n);
	press_c:     cover property (power_button_event);
	halt_c:      cover property (boot_halted [*3]);

endmodule : module_power_mgmt_boot_select

// ===== rtl/pm_boot_consts.svh
`ifndef PM_BOOT_CONSTS_SVH
`define PM_BOOT_CONSTS_SVH

// Clock period of ref_clk in ns
`define PM_CLK_PERIOD_NS   5
// Debounce settle time in ns and its cycle count (least time, rounded up)
`define PM_DEB_TIME_NS     10000
`define PM_DEB_CYCLES      ((`PM_DEB_TIME_NS + `PM_CLK_PERIOD_NS - 1) / `PM_CLK_PERIOD_NS)
// Time the module stays in reset after supplies come up, in ns and cycles
`define PM_RST_HOLD_NS     1000
`define PM_RST_HOLD_CYCLES ((`PM_RST_HOLD_NS + `PM_CLK_PERIOD_NS - 1) / `PM_CLK_PERIOD_NS)
// Idle level of a pulled-up carrier line in the synchronisers
`define PM_PIN_IDLE        1'b1
// Boot code held until the first strap capture: on-module SPI
`define PM_BOOT_CODE_RST   3'h7
// Configuration strap levels held until the first capture
`define PM_CFG_RST         2'h0
// Strap pattern that selects the carrier SPI device
`define PM_CARRIER_SPI_PAT 3'h3
// Debounced input positions
`define PM_DEB_BUTTON      0
`define PM_DEB_SLEEP       1
`define PM_DEB_LID         2
`define PM_DEB_NUM         3

`endif

// ===== rtl/pm_boot_pkg.sv
package pm_boot_pkg;

	typedef enum logic [4:0] {
		ST_OFF     = 5'h01,
		ST_RESET   = 5'h02,
		ST_BOOT    = 5'h04,
		ST_RUN     = 5'h08,
		ST_STANDBY = 5'h10
	} pm_state_t;

	// Code equals the strap pins {bit2,bit1,bit0}: grounded reads 0, floating 1
	typedef enum logic [2:0] {
		BOOT_CARRIER_SATA = 3'h0,
		BOOT_CARRIER_SD   = 3'h1,
		BOOT_CARRIER_ESPI = 3'h2,
		BOOT_CARRIER_SPI  = 3'h3,
		BOOT_MODULE_DEV   = 3'h4,
		BOOT_REMOTE       = 3'h5,
		BOOT_MODULE_EMMC  = 3'h6,
		BOOT_MODULE_SPI   = 3'h7
	} boot_source_t;

endpackage : pm_boot_pkg

// ===== verification/carrier_board_model.sv
`timescale 1ns/1ps
module carrier_board_model (
	input  wire logic       carrier_power_on,
	input  wire logic [9:0] pull_low,
	input  wire logic [2:0] strap_float,
	output logic      [9:0] line_n,
	output logic      [2:0] strap_n,
	output logic            carrier_powered
);
	// Open-drain lines: a released line rises through the module pull-up
	assign line_n = ~pull_low;
	// Straps are ground or float only; no loads that would move the level
	assign strap_n = strap_float;
	assign carrier_powered = carrier_power_on;
endmodule : carrier_board_model

// ===== verification/module_power_mgmt_boot_select_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end
module module_power_mgmt_boot_select_tb_top;
	import pm_boot_pkg::*;
	logic         ref_clk = 1'h0, rstn = 1'h0, standby_req = 1'h0, boot_done = 1'h0;
	logic         flash_s = 1'h1, audio_s = 1'h1;
	logic [9:0]   pull_low = 10'h000;
	logic [2:0]   strap = 3'h3;
	wire  [9:0]   line_n;
	wire  [2:0]   strap_n;
	wire          carrier_powered;
	logic         supply_enable, carrier_power_on, carrier_standby_n, module_reset_n;
	logic         boot_halted, power_button_event, sleep_request, lid_closed;
	logic         battery_low, charging, charger_present, test_mode, pm_alert_irq;
	logic         boot_from_carrier_spi, flash_strap_q, audio_strap_q;
	boot_source_t boot_source;
	int           errors = 0, n_tests = 0;
	wire  [4:0]   st = {pm_alert_irq, test_mode, charger_present, charging, battery_low};

	always #2.5 ref_clk = ~ref_clk;

	carrier_board_model i_carrier (.carrier_power_on(carrier_power_on), .pull_low(pull_low),
		.strap_float(strap), .line_n(line_n), .strap_n(strap_n),
		.carrier_powered(carrier_powered));

	// Short counts keep the run brief; the debounce waits below are fixed cycle counts sized for DEB_CYCLES of 4
	module_power_mgmt_boot_select #(.DEB_CYCLES(4), .RST_CYCLES(4)) i_dut (
		.ref_clk(ref_clk), .rstn(rstn), .input_power_bad_n(line_n[0]),
		.reset_in_n(line_n[1]), .power_button_n(line_n[2]), .sleep_n(line_n[3]),
		.lid_n(line_n[4]), .battery_low_n(line_n[5]), .charging_n(line_n[6]),
		.charger_present_n(line_n[7]), .test_n(line_n[8]), .pm_bus_alert_n(line_n[9]),
		.boot_strap_bit0_n(strap_n[0]), .boot_strap_bit1_n(strap_n[1]),
		.boot_strap_bit2_n(strap_n[2]), .flash_data_out_strap(flash_s),
		.audio_data_out_strap(audio_s), .standby_req(standby_req), .boot_done(boot_done),
		.supply_enable(supply_enable), .carrier_power_on(carrier_power_on),
		.carrier_standby_n(carrier_standby_n), .module_reset_n(module_reset_n),
		.boot_halted(boot_halted), .power_button_event(power_button_event),
		.sleep_request(sleep_request), .lid_closed(lid_closed), .battery_low(battery_low),
		.charging(charging), .charger_present(charger_present), .test_mode(test_mode),
		.pm_alert_irq(pm_alert_irq), .boot_source(boot_source),
		.boot_from_carrier_spi(boot_from_carrier_spi), .flash_strap_q(flash_strap_q),
		.audio_strap_q(audio_strap_q));

	////////////////////////////////////////////////////////////
	task stop_test;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	task cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc

	task pull(input int i, input logic v);
		@(posedge ref_clk);
		pull_low[i] <= v;
	endtask : pull

	task wait_rst;
		int k;
		k = 0;
		while (module_reset_n !== 1'h1 && k < 100)
		begin
			cyc(1);
			k++;
		end
		if (k == 100)
		begin
			errors++;
			stop_test();
		end
	endtask : wait_rst

	task chk_boot(input logic [2:0] p);
		wait_rst();
		`CHK("supply", 1'h1, supply_enable)
		`CHK("source", p, boot_source)
		`CHK("carrier_spi", p == 3'h3, boot_from_carrier_spi)
		`CHK("flash_strap", p[0], flash_strap_q)
		`CHK("audio_strap", p[1], audio_strap_q)
	endtask : chk_boot

	////////////////////////////////////////////////////////////
	task t_halt;
		pull(2, 1'h1);
		cyc(3);
		`CHK("halt_early", 1'h0, boot_halted)
		cyc(6);
		`CHK("halted", 1'h1, boot_halted)
		@(posedge ref_clk) boot_done <= 1'h1;
		@(posedge ref_clk) boot_done <= 1'h0;
		standby_req <= 1'h1;
		cyc(3);
		// Still booting, so standby must not be entered
		`CHK("stby_in_boot", 1'h1, carrier_standby_n)
		@(posedge ref_clk) standby_req <= 1'h0;
		pull(2, 1'h0);
		cyc(8);
		`CHK("unhalted", 1'h0, boot_halted)
		@(posedge ref_clk) boot_done <= 1'h1;
		@(posedge ref_clk) boot_done <= 1'h0;
		$display("t_halt end");
	endtask : t_halt

	task t_run;
		integer c;
		@(posedge ref_clk) standby_req <= 1'h1;
		cyc(2);
		`CHK("stby_on", 1'h0, carrier_standby_n)
		@(posedge ref_clk) standby_req <= 1'h0;
		cyc(2);
		`CHK("stby_off", 1'h1, carrier_standby_n)
		pull(2, 1'h1);
		c = 0;
		repeat (12) begin cyc(1); c += power_button_event; end
		`CHK("btn_events", 1, c)
		pull(2, 1'h0);
		pull(4, 1'h1);
		pull(4, 1'h0);
		c = 0;
		repeat (10) begin cyc(1); c += lid_closed; end
		`CHK("lid_glitch", 0, c)
		pull(4, 1'h1);
		cyc(8);
		`CHK("lid", 1'h1, lid_closed)
		`CHK("lid_sleep", 1'h1, sleep_request)
		pull(4, 1'h0);
		pull(3, 1'h1);
		cyc(8);
		`CHK("sleep", 1'h1, sleep_request)
		pull(3, 1'h0);
		cyc(8);
		`CHK("no_sleep", 1'h0, sleep_request)
		$display("t_run end");
	endtask : t_run

	task t_status;
		for (int i = 0; i < 5; i++)
		begin
			pull(5 + i, 1'h1);
			cyc(3);
			`CHK("status", 5'h01 << i, st)
			pull(5 + i, 1'h0);
			cyc(3);
		end
		$display("t_status end");
	endtask : t_status

	task t_pbad;
		pull(0, 1'h1);
		cyc(4);
		`CHK("pbad_supply", 1'h0, supply_enable)
		`CHK("pbad_carrier", 1'h0, carrier_power_on)
		`CHK("carrier_down", 1'h0, carrier_powered)
		pull(0, 1'h0);
		chk_boot(3'h3);
		$display("t_pbad end");
	endtask : t_pbad

	task t_strap;
		for (int p = 0; p < 8; p++)
		begin
			@(posedge ref_clk);
			strap <= p[2:0];
			flash_s <= p[0];
			audio_s <= p[1];
			pull(1, 1'h1);
			cyc(4);
			`CHK("reset_in", 1'h0, module_reset_n)
			pull(1, 1'h0);
			chk_boot(p[2:0]);
		end
		$display("t_strap end");
	endtask : t_strap

	initial
	begin
		repeat (16) @(posedge ref_clk);
		rstn <= 1'h1;
		chk_boot(3'h3);
		`CHK("standby_idle", 1'h1, carrier_standby_n)
		t_halt();
		t_run();
		t_status();
		t_pbad();
		t_strap();
		stop_test();
	end
endmodule : module_power_mgmt_boot_select_tb_top
